/* File: tb/mcx_slave_model.sv */
// Behavioural model of the flash, SRAM and bridge slaves
`timescale 1ns/1ps
`include "mcx_consts.svh"
module mcx_slave_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`MCX_NUM_S-1:0] s_req_i,
  input wire logic [`MCX_NUM_S-1:0][`MCX_AW-1:0] s_addr_i,
  input wire logic [`MCX_NUM_S-1:0][3:0] wait_i,
  output logic [`MCX_NUM_S-1:0] s_ready_o,
  output logic [`MCX_NUM_S-1:0][`MCX_DW-1:0] s_rdata_o
);
  logic [`MCX_NUM_S-1:0][3:0] cnt;
  // Ready after the wait states; data is the inverse pattern outside that cycle
  always_comb begin
    for (int s = 0; s < `MCX_NUM_S; s++) begin
      s_ready_o[s] = s_req_i[s] && (cnt[s] == wait_i[s]);
      s_rdata_o[s] = s_addr_i[s] ^ (s_ready_o[s] ? 32'h5A5A5A5A : 32'hA5A5A5A5);
    end
  end
  // Wait counter restarts on each completed beat
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < `MCX_NUM_S; s++) begin
      cnt[s] <= (!rst_i && s_req_i[s] && !s_ready_o[s]) ? cnt[s] + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: tb/tb_mcx_crossbar_switch.sv */
// Self-checking testbench of the crossbar switch
`timescale 1ns/1ps
`include "mcx_consts.svh"
module tb_mcx_crossbar_switch;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] m_req = '0, m_we = '0, m_burst = '0, m_elev = '0, m_ack, m_stall;
  logic [3:0][31:0] m_addr = '0, m_wdata = '0, m_rdata;
  logic [2:0] s_req, s_we, s_ready;
  logic [2:0][31:0] s_addr, s_wdata, s_rdata;
  logic [2:0][3:0] wt = {4'h0, 4'h4, 4'h3};
  logic [1:0] order[$];
  int bad_count = 0, check_count = 0, cyc = 0, ovl = 0;
  int ackc[4];

  // System clock, 100 ns period
  always #50 clk_i = ~clk_i;

  mcx_crossbar_switch i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .m_req_i(m_req),
    .m_we_i(m_we), .m_burst_i(m_burst), .m_elev_i(m_elev), .m_addr_i(m_addr),
    .m_wdata_i(m_wdata), .m_ack_o(m_ack), .m_stall_o(m_stall), .m_rdata_o(m_rdata),
    .s_req_o(s_req), .s_we_o(s_we), .s_addr_o(s_addr), .s_wdata_o(s_wdata),
    .s_ready_i(s_ready), .s_rdata_i(s_rdata));
  mcx_slave_model i_slv (.clk_i(clk_i), .rst_i(sys_rst_i), .s_req_i(s_req),
    .s_addr_i(s_addr), .wait_i(wt), .s_ready_o(s_ready), .s_rdata_o(s_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ack order, write data, overlap and hang watch, sampled mid-cycle where settled
  always @(negedge clk_i) begin
    cyc++;
    for (int m = 0; m < 4; m++) begin
      if (m_ack[m] === 1'b1) begin
        order.push_back(2'(m));
        ackc[m] = cyc;
      end
    end
    for (int s = 0; s < 3; s++) begin
      if (s_req[s] && s_ready[s] && s_we[s]) chk(s_wdata[s], ~s_addr[s]);
    end
    if (s_req[1] && s_req[2]) chk({29'h0, s_req}, 32'h0);
    if (s_req[0] && s_req[1]) ovl++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // One beat of master m; bit 2 of the address selects a write
  task automatic beat(input int m, input logic [31:0] a, input logic b = 0, input logic e = 0);
    int n;
    n = 0;
    m_addr[m] <= a;
    m_wdata[m] <= ~a;
    m_we[m] <= a[2];
    m_burst[m] <= b;
    m_elev[m] <= e;
    m_req[m] <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (m_ack[m] !== 1'b1 && n < 80);
    if (m_ack[m] !== 1'b1) chk({31'h0, m_ack[m]}, 32'h1);
    if (!a[2]) chk(m_rdata[m], a ^ 32'h5A5A5A5A);
    if (!b) begin
      m_req[m] <= 1'b0;
      m_elev[m] <= 1'b0;
    end
  endtask

  task automatic order_is(input logic [31:0] exp);
    logic [31:0] got;
    got = '0;
    foreach (order[i]) got = {got[29:0], order[i]};
    chk(got, exp);
    order.delete();
  endtask

  task automatic s_map();
    beat(1, 32'h00000040);
    beat(2, 32'h40000044);
    beat(3, 32'h80000048);
    beat(0, 32'hC0000050);
    beat(1, 32'h40000054);
    order_is({2'h1, 2'h2, 2'h3, 2'h0, 2'h1});
  endtask

  task automatic s_prio();
    fork
      beat(3, 32'h40000100);
      beat(2, 32'h40000200);
      beat(1, 32'h40000300);
    join_none
    repeat (3) @(posedge clk_i);
    chk({28'h0, m_stall}, 32'hC);
    wait fork;
    order_is({2'h1, 2'h2, 2'h3});
  endtask

  task automatic s_elev();
    fork
      beat(1, 32'h40000400);
      beat(3, 32'h40000500, 1'b0, 1'b1);
    join
    order_is({2'h3, 2'h1});
    @(posedge clk_i);
    fork
      beat(1, 32'h40000600);
      beat(3, 32'h40000700);
    join
    order_is({2'h1, 2'h3});
    @(posedge clk_i);
    fork
      beat(0, 32'h00001000);
      beat(3, 32'h00001100, 1'b0, 1'b1);
    join
    order_is({2'h3, 2'h0});
  endtask

  task automatic s_rr();
    beat(2, 32'h80000800);
    fork
      beat(1, 32'h80000900, 1'b0, 1'b1);
      beat(3, 32'hC0000A00, 1'b0, 1'b1);
    join
    order_is({2'h2, 2'h3, 2'h1});
  endtask

  task automatic s_burst();
    fork
      begin
        beat(2, 32'h40000B00, 1'b1);
        beat(2, 32'h40000B08);
      end
      begin
        @(posedge clk_i);
        beat(1, 32'h40000C00);
      end
    join
    order_is({2'h2, 2'h2, 2'h1});
    chk(32'(ackc[1] - ackc[2]), 32'(wt[1]) + 32'h1);
  endtask

  task automatic s_conc();
    fork
      beat(0, 32'h00000D00);
      beat(1, 32'h40000E00);
    join
    chk(32'(ovl > 0), 32'h1);
    order_is({2'h0, 2'h1});
    @(posedge clk_i);
    fork
      beat(1, 32'h40000F00);
      beat(2, 32'h80000F00);
    join
    order_is({2'h1, 2'h2});
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk({21'h0, m_ack, m_stall, s_req}, 32'h0);
    s_map();
    @(posedge clk_i);
    s_prio();
    @(posedge clk_i);
    s_elev();
    @(posedge clk_i);
    s_rr();
    @(posedge clk_i);
    s_burst();
    @(posedge clk_i);
    s_conc();
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule

/* File: verilog/mcx_addr_decode.sv */
// Address decoder that picks the target slave port of one master
`timescale 1ns/1ps
`include "mcx_consts.svh"
module mcx_addr_decode (
  input wire logic [`MCX_AW-1:0] addr_i,
  output mcx_pkg::mcx_sid_t sel_o
);
  // Top address bits choose flash, SRAM or the peripheral bridge
  function automatic mcx_pkg::mcx_sid_t region(input logic [`MCX_AW-1:0] a);
    logic [1:0] hi;
    hi = a[`MCX_MAP_HI:`MCX_MAP_LO];
    if (hi == `MCX_REG_FLASH) begin
      region = `MCX_SLV_FLASH;
    end else if (hi == `MCX_REG_SRAM) begin
      region = `MCX_SLV_SRAM;
    end else begin
      region = `MCX_SLV_BRIDGE;
    end
  endfunction

  assign sel_o = region(addr_i);
endmodule

/* File: verilog/mcx_arbiter.sv */
// Priority arbiter with round robin among equal levels for one slave port
`timescale 1ns/1ps
`include "mcx_consts.svh"
module mcx_arbiter (
  input wire logic [`MCX_NUM_M-1:0] req_i,
  input wire logic [`MCX_NUM_M-1:0] elev_i,
  input wire logic [1:0] last_i,
  output logic valid_o,
  output mcx_pkg::mcx_mid_t win_o
);
  // Fixed level from the port index, lifted to the top while elevated
  function automatic logic [2:0] level(input logic [1:0] m, input logic up);
    level = up ? `MCX_LVL_ELEV : 3'({1'b0, m} + 3'h1);
  endfunction

  // Best level first, then the next requester after the last grant
  always_comb begin
    logic [2:0] best;
    logic [1:0] idx;
    best = `MCX_LVL_NONE;
    idx = 2'h0;
    valid_o = 1'b0;
    win_o = 2'h0;
    for (int k = 0; k < `MCX_NUM_M; k++) begin
      if (req_i[k] && level(2'(k), elev_i[k]) < best) begin
        best = level(2'(k), elev_i[k]);
      end
    end
    for (int k = 1; k <= `MCX_NUM_M; k++) begin
      idx = 2'(last_i + 2'(k));
      if (!valid_o && req_i[idx] && level(idx, elev_i[idx]) == best) begin
        valid_o = 1'b1;
        win_o = idx;
      end
    end
  end
endmodule

/* File: verilog/mcx_consts.svh */
// Constants of the multiport crossbar switch
`ifndef MCX_CONSTS_SVH
`define MCX_CONSTS_SVH
`define MCX_NUM_M 4
`define MCX_NUM_S 3
`define MCX_AW 32
`define MCX_DW 32
`define MCX_MST_IFETCH 2'h0
`define MCX_MST_LSU 2'h1
`define MCX_MST_DMA 2'h2
`define MCX_MST_NET 2'h3
`define MCX_SLV_FLASH 2'h0
`define MCX_SLV_SRAM 2'h1
`define MCX_SLV_BRIDGE 2'h2
`define MCX_MAP_HI 31
`define MCX_MAP_LO 30
`define MCX_REG_FLASH 2'h0
`define MCX_REG_SRAM 2'h1
`define MCX_LVL_ELEV 3'h0
`define MCX_LVL_NONE 3'h7
`define MCX_MAX_BUSY 2'h2
`endif

/* File: verilog/mcx_crossbar_switch.sv */
// Crossbar switch joining four bus masters to three bus slaves
// Contract
// - Four master ports, three slave ports, distinct pairs connected at once.
// - Every port carries 32-bit address and 32-bit data; parties use those widths.
// - At most two transfers at once, one being an instruction fetch from flash.
// - Several masters on one slave: the higher priority requester wins the port.
// - Losing masters stall until the winner finishes its transfers there.
// - Equal priorities rotate round robin after the last granted master.
// - Base priority is fixed by the master port.
// - A master may be raised above its base level, then falls back.
// - Masters are instruction fetch, load/store, DMA engine, network controller.
// - Slaves are flash, SRAM and peripheral bridge, each reachable from any master.
`timescale 1ns/1ps
`include "mcx_consts.svh"
module mcx_crossbar_switch (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`MCX_NUM_M-1:0] m_req_i,
  input wire logic [`MCX_NUM_M-1:0] m_we_i,
  input wire logic [`MCX_NUM_M-1:0] m_burst_i,
  input wire logic [`MCX_NUM_M-1:0] m_elev_i,
  input wire logic [`MCX_NUM_M-1:0][`MCX_AW-1:0] m_addr_i,
  input wire logic [`MCX_NUM_M-1:0][`MCX_DW-1:0] m_wdata_i,
  output logic [`MCX_NUM_M-1:0] m_ack_o,
  output logic [`MCX_NUM_M-1:0] m_stall_o,
  output logic [`MCX_NUM_M-1:0][`MCX_DW-1:0] m_rdata_o,
  output logic [`MCX_NUM_S-1:0] s_req_o,
  output logic [`MCX_NUM_S-1:0] s_we_o,
  output logic [`MCX_NUM_S-1:0][`MCX_AW-1:0] s_addr_o,
  output logic [`MCX_NUM_S-1:0][`MCX_DW-1:0] s_wdata_o,
  input wire logic [`MCX_NUM_S-1:0] s_ready_i,
  input wire logic [`MCX_NUM_S-1:0][`MCX_DW-1:0] s_rdata_i
);
  mcx_pkg::mcx_crossbar_switch_state_t st;
  mcx_pkg::mcx_crossbar_switch_state_t next_st;
  logic [`MCX_NUM_M-1:0] eff_req;
  logic [`MCX_NUM_M-1:0][1:0] sel;
  logic [`MCX_NUM_S-1:0] done;
  logic [`MCX_NUM_S-1:0] rel;
  logic [`MCX_NUM_S-1:0][`MCX_NUM_M-1:0] cand;
  logic [`MCX_NUM_S-1:0] arb_vld;
  logic [`MCX_NUM_S-1:0][1:0] arb_win;

  // Only the flash port serving the instruction fetch master counts as a fetch
  function automatic logic is_fetch(input logic [1:0] s, input logic [1:0] m);
    is_fetch = (s == `MCX_SLV_FLASH) && (m == `MCX_MST_IFETCH);
  endfunction

  // A request seen while its answer is still out is the old beat: mask it
  assign eff_req = m_req_i & ~st.ack;

  // One decoder per master port, in the order fetch, load/store, DMA, network
  for (genvar m = 0; m < `MCX_NUM_M; m++) begin : g_dec
    mcx_addr_decode u_dec (
      .addr_i(m_addr_i[m]),
      .sel_o(sel[m])
    );
  end

  // One arbiter per slave port; the present owner does not compete for it while the port is busy
  for (genvar s = 0; s < `MCX_NUM_S; s++) begin : g_arb
    assign done[s] = st.sreq[s] & s_ready_i[s];
    assign rel[s] = done[s] & ~st.sburst[s];
    for (genvar m = 0; m < `MCX_NUM_M; m++) begin : g_cand
      assign cand[s][m] = eff_req[m] && (sel[m] == 2'(s)) &&
                          !(st.busy[s] && st.owner[s] == 2'(m));
    end
    mcx_arbiter u_arb (
      .req_i(cand[s]),
      .elev_i(m_elev_i),
      .last_i(st.last[s]),
      .valid_o(arb_vld[s]),
      .win_o(arb_win[s])
    );
  end

  // Next state: retire beats, continue bursts, grant free ports, flag stalls
  always_comb begin
    logic [1:0] cnt;
    logic fetch_in;
    logic [1:0] w;
    logic [`MCX_NUM_M-1:0] fin;
    next_st = st;
    cnt = 2'h0;
    fetch_in = 1'b0;
    w = 2'h0;
    fin = '0;
    next_st.ack = '0;
    // Completed beats answer their master; a last beat frees the port
    for (int s = 0; s < `MCX_NUM_S; s++) begin
      if (done[s]) begin
        w = st.owner[s];
        fin[w] = 1'b1;
        next_st.ack[w] = 1'b1;
        next_st.rdata[w] = s_rdata_i[s];
        next_st.sreq[s] = 1'b0;
        if (!st.sburst[s]) begin
          next_st.busy[s] = 1'b0;
        end
      end
    end
    // The owner of a burst issues its next beat without arbitration
    for (int s = 0; s < `MCX_NUM_S; s++) begin
      w = st.owner[s];
      if (st.busy[s] && !st.sreq[s] && eff_req[w] && sel[w] == 2'(s)) begin
        next_st.sreq[s] = 1'b1;
        next_st.swe[s] = m_we_i[w];
        next_st.sburst[s] = m_burst_i[w];
        next_st.saddr[s] = m_addr_i[w];
        next_st.swdata[s] = m_wdata_i[w];
      end
    end
    // Count the transfers that stay open this cycle
    for (int s = 0; s < `MCX_NUM_S; s++) begin
      if (next_st.busy[s]) begin
        cnt = 2'(cnt + 2'h1);
        if (is_fetch(2'(s), next_st.owner[s])) begin
          fetch_in = 1'b1;
        end
      end
    end
    // Free ports go to their arbiter winner while the pairing limit allows
    for (int s = 0; s < `MCX_NUM_S; s++) begin
      w = arb_win[s];
      if (!next_st.busy[s] && arb_vld[s] &&
          (cnt == 2'h0 || (cnt < `MCX_MAX_BUSY && (fetch_in || is_fetch(2'(s), w))))) begin
        next_st.busy[s] = 1'b1;
        next_st.owner[s] = w;
        next_st.last[s] = w;
        next_st.sreq[s] = 1'b1;
        next_st.swe[s] = m_we_i[w];
        next_st.sburst[s] = m_burst_i[w];
        next_st.saddr[s] = m_addr_i[w];
        next_st.swdata[s] = m_wdata_i[w];
        cnt = 2'(cnt + 2'h1);
        fetch_in = fetch_in | is_fetch(2'(s), w);
      end
    end
    // A master waits while its request is neither served nor answered
    for (int m = 0; m < `MCX_NUM_M; m++) begin
      w = sel[m];
      next_st.stall[m] = eff_req[m] && !fin[m] &&
                         !(next_st.busy[w] && next_st.owner[w] == 2'(m));
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign m_ack_o = st.ack;
  assign m_stall_o = st.stall;
  assign m_rdata_o = st.rdata;
  assign s_req_o = st.sreq;
  assign s_we_o = st.swe;
  assign s_addr_o = st.saddr;
  assign s_wdata_o = st.swdata;

  // Checks on arbitration, pairing and hand-over
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_bridge_beat;
    st.sreq[2] && s_ready_i[2];
  endsequence

  sequence s_sram_handoff;
    rel[1] && (cand[1] != '0) && (cand[0] == '0) && !st.busy[0] && !st.busy[2];
  endsequence

  sequence s_sram_beat;
    st.sreq[1] && s_ready_i[1];
  endsequence

  sequence s_sram_burst_beat;
    st.sreq[1] && s_ready_i[1] && st.sburst[1];
  endsequence

  sequence s_bridge_grant;
    !st.busy[2] ##1 st.busy[2];
  endsequence

  sequence s_net_blocked;
    m_req_i[3] && !st.ack[3] && sel[3] == 2'h1 && st.busy[1] && st.owner[1] != 2'h3 &&
    !rel[1] && !st.busy[0] && !st.busy[2];
  endsequence

  a_busy_limit:
    assert property ($countones(st.busy) <= 2)
    else $error("more than two slave ports busy");

  a_pair_fetch:
    assert property ($countones(st.busy) == 2 |-> st.busy[0] && st.owner[0] == 2'h0)
    else $error("two transfers without a flash instruction fetch");

  a_fixed_prio:
    assert property (!st.busy[0] && cand[0][0] && m_elev_i[3:1] == 3'h0
                     |=> st.busy[0] && st.owner[0] == 2'h0 && st.sreq[0])
    else $error("flash not granted to the fetch master");

  a_elev_wins:
    assert property (st.busy == '0 && cand[0][3] && m_elev_i == 4'h8
                     |=> st.busy[0] && st.owner[0] == 2'h3)
    else $error("elevated master did not win flash");

  a_rr_turn:
    assert property (st.busy == '0 && cand[2] == 4'hA && m_elev_i == 4'hA &&
                     st.last[2] == 2'h2 |=> st.owner[2] == 2'h3)
    else $error("round robin did not move past last grant");

  a_owner_hold:
    assert property (st.busy[1] && !rel[1]
                     |=> st.busy[1] && st.owner[1] == $past(st.owner[1]))
    else $error("sram port changed owner before completion");

  a_beat_answer:
    assert property (s_bridge_beat |=> st.ack[$past(st.owner[2])] &&
                     st.rdata[$past(st.owner[2])] == $past(s_rdata_i[2]))
    else $error("completed bridge beat not answered");

  a_rearb_gap:
    assert property (s_sram_handoff |=> st.busy[1] && st.sreq[1] &&
                     st.owner[1] != $past(st.owner[1]))
    else $error("sram port idled with requests pending");

  // One-cycle answers and stall flags that never overlap them
  a_ack_pulse:
    assert property ((st.ack & $past(st.ack)) == '0)
    else $error("acknowledge held for two cycles");

  a_stall_excl:
    assert property ((st.stall & st.ack) == '0)
    else $error("master stalled in its answer cycle");

  a_stall_cause:
    assert property ((st.stall & ~$past(m_req_i)) == '0)
    else $error("stall flagged without a request");

  a_net_stall:
    assert property (s_net_blocked |=> st.stall[3])
    else $error("blocked network master not stalled");

  // Port ownership and presented beats
  a_req_owned:
    assert property ((st.sreq & ~st.busy) == '0)
    else $error("slave beat presented on a free port");

  a_idle_grant:
    assert property (!st.busy[2] && cand[2] == '0 |=> !st.busy[2])
    else $error("bridge granted without a requester");

  a_index_prio:
    assert property (st.busy == '0 && cand[2][0] && cand[1:0] == '0 && m_elev_i == 4'h0
                     |=> st.busy[2] && st.owner[2] == 2'h0)
    else $error("bridge not granted to the lowest port index");

  a_last_grant:
    assert property (s_bridge_grant |-> st.last[2] == st.owner[2])
    else $error("round robin pointer not updated on grant");

  a_fetch_pairs:
    assert property (st.busy == '0 && cand[0][0] && cand[1] != '0 && m_elev_i == 4'h0
                     |=> st.busy[0] && st.busy[1] && st.owner[0] == 2'h0)
    else $error("fetch and sram transfer not paired");

  a_flash_hold:
    assert property (st.busy[0] && !rel[0] |=> st.busy[0] && $stable(st.owner[0]))
    else $error("flash port changed owner before completion");

  a_bridge_hold:
    assert property (st.busy[2] && !rel[2] |=> st.busy[2] && $stable(st.owner[2]))
    else $error("bridge port changed owner before completion");

  a_beat_stable:
    assert property (st.sreq[1] && !s_ready_i[1] |=> st.sreq[1] && $stable(st.saddr[1]) &&
                     $stable(st.swdata[1]) && $stable(st.swe[1]))
    else $error("sram beat changed before the slave was ready");

  a_flash_stable:
    assert property (st.sreq[0] && !s_ready_i[0] |=> st.sreq[0] && $stable(st.saddr[0]))
    else $error("flash beat changed before the slave was ready");

  // Burst continuation and answers on the sram and flash ports
  a_burst_keep:
    assert property (s_sram_burst_beat |=> st.busy[1] && !st.sreq[1] &&
                     st.owner[1] == $past(st.owner[1]))
    else $error("sram port released inside a burst");

  a_sram_answer:
    assert property (s_sram_beat |=> st.ack[$past(st.owner[1])] &&
                     st.rdata[$past(st.owner[1])] == $past(s_rdata_i[1]))
    else $error("completed sram beat not answered");

  a_flash_answer:
    assert property (st.sreq[0] && s_ready_i[0] |=> st.ack[$past(st.owner[0])])
    else $error("completed flash beat not answered");

  a_rdata_hold:
    assert property ($changed(st.rdata[1]) |-> st.ack[1])
    else $error("read data moved without an answer");
endmodule

/* File: verilog/mcx_pkg.sv */
// Types of the multiport crossbar switch
`include "mcx_consts.svh"
package mcx_pkg;
  typedef logic [1:0] mcx_mid_t;
  typedef logic [1:0] mcx_sid_t;
  typedef struct packed {
    logic [`MCX_NUM_S-1:0] busy;
    logic [`MCX_NUM_S-1:0][1:0] owner;
    logic [`MCX_NUM_S-1:0][1:0] last;
    logic [`MCX_NUM_S-1:0] sreq;
    logic [`MCX_NUM_S-1:0] swe;
    logic [`MCX_NUM_S-1:0] sburst;
    logic [`MCX_NUM_S-1:0][`MCX_AW-1:0] saddr;
    logic [`MCX_NUM_S-1:0][`MCX_DW-1:0] swdata;
    logic [`MCX_NUM_M-1:0] ack;
    logic [`MCX_NUM_M-1:0] stall;
    logic [`MCX_NUM_M-1:0][`MCX_DW-1:0] rdata;
  } mcx_crossbar_switch_state_t;
endpackage
